// *** mem_io_pkg.sv ***
// Package for the processor memory and I/O interface bridge.
// Assumes one 40 MHz clock and a one-cycle tick per processor clock period.
package mem_io_pkg;

  localparam int CLK_HZ = 40_000_000;
  localparam logic [3:0] NIBBLE_ZERO = 4'h0;
  localparam logic [3:0] CS_PROG_MEM = 4'hF;
  localparam logic [7:0] SEL_RESET = 8'h00;

  // Opcode nibbles of the I/O instruction group seen on the data bus.
  localparam logic [3:0] OP_IO_GROUP = 4'hE;
  localparam logic [3:0] OP_WRITE_PORT = 4'h2;
  localparam logic [3:0] OP_WRITE_PM = 4'h3;
  localparam logic [3:0] OP_READ_PM = 4'h9;
  localparam logic [3:0] OP_READ_PORT = 4'hA;

  typedef enum {
    ST_A1, ST_A2, ST_A3, ST_M1, ST_M2, ST_X1, ST_X2, ST_X3
  } cycle_state_t;

  typedef enum {
    INS_OTHER, INS_WRITE_PORT, INS_READ_PORT, INS_WRITE_PM, INS_READ_PM
  } instr_kind_t;

  typedef struct packed {
    logic [3:0] chip_sel;
    logic [7:0] addr;
  } mem_addr_t;

endpackage : mem_io_pkg

// *** mem_io_bridge.sv ***
// Bridge between a 4-bit multiplexed processor bus, byte-wide program memory and I/O ports.
// Assumes all inputs are synchronous to clk and that state_tick pulses once per
// processor clock period, with sync_n low in the period before address state 1.
`timescale 1ns/1ps

module mem_io_bridge (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Processor timing and control
  input wire logic state_tick,
  input wire logic sync_n,
  input wire logic command_line_n,
  // Processor data bus
  input wire logic [3:0] data_in,
  output logic [3:0] data_out,
  output logic data_oe_n,
  // Program memory
  output mem_io_pkg::mem_addr_t mem_addr,
  input wire logic [3:0] high_nibble_in,
  input wire logic [3:0] low_nibble_in,
  output logic prog_mem_strobe_n,
  output logic half_select_n,
  // I/O port
  input wire logic [3:0] io_in,
  output logic [3:0] io_out,
  output logic io_oe_n,
  output logic in_strobe_n,
  output logic out_strobe_n
);
  import mem_io_pkg::*;

  cycle_state_t state;
  instr_kind_t kind;
  logic [3:0] op_high;
  logic cmd_a3;
  logic cmd_m2;
  logic [7:0] sel_reg;
  logic half_sel;
  logic [3:0] port_data;
  logic pm_active;

  function automatic logic is_pm(input instr_kind_t k);
    is_pm = (k == INS_WRITE_PM) || (k == INS_READ_PM);
  endfunction : is_pm

  function automatic logic is_read(input instr_kind_t k);
    is_read = (k == INS_READ_PORT) || (k == INS_READ_PM);
  endfunction : is_read

  function automatic logic is_write(input instr_kind_t k);
    is_write = (k == INS_WRITE_PORT) || (k == INS_WRITE_PM);
  endfunction : is_write

  function automatic instr_kind_t decode(input logic [3:0] hi, input logic [3:0] lo);
    decode = INS_OTHER;
    if (hi == OP_IO_GROUP) begin
      case (lo)
        OP_WRITE_PORT: decode = INS_WRITE_PORT;
        OP_READ_PORT: decode = INS_READ_PORT;
        OP_WRITE_PM: decode = INS_WRITE_PM;
        OP_READ_PM: decode = INS_READ_PM;
        default: decode = INS_OTHER;
      endcase
    end
  endfunction : decode

  // Cycle sequencer; sync realigns it so a missed tick cannot skew later cycles.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state <= ST_A1;
    end else if (state_tick) begin
      if (!sync_n) begin
        state <= ST_A1;
      end else begin
        case (state)
          ST_A1: state <= ST_A2;
          ST_A2: state <= ST_A3;
          ST_A3: state <= ST_M1;
          ST_M1: state <= ST_M2;
          ST_M2: state <= ST_X1;
          ST_X1: state <= ST_X2;
          ST_X2: state <= ST_X3;
          ST_X3: state <= ST_A1;
          default: state <= ST_A1;
        endcase
      end
    end
  end

  // Command sampling and instruction decode from the fetched nibbles.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cmd_a3 <= 1'b0;
      cmd_m2 <= 1'b0;
      op_high <= NIBBLE_ZERO;
      kind <= INS_OTHER;
    end else if (state_tick) begin
      case (state)
        ST_A3: cmd_a3 <= !command_line_n;
        ST_M1: op_high <= data_in;
        ST_M2: begin
          cmd_m2 <= !command_line_n;
          // Only an instruction flagged by the command line is treated as I/O.
          kind <= command_line_n ? INS_OTHER : decode(op_high, data_in);
        end
        ST_X3: kind <= INS_OTHER;
        default: ;
      endcase
    end
  end

  // Select register, written only by an instruction outside the I/O group.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sel_reg <= SEL_RESET;
    end else if (state_tick && !command_line_n && kind == INS_OTHER && !cmd_m2) begin
      if (state == ST_X2) begin
        sel_reg[7:4] <= data_in;
      end else if (state == ST_X3) begin
        sel_reg[3:0] <= data_in;
      end
    end
  end

  // Address and chip-select outputs.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mem_addr <= '0;
    end else if (state_tick) begin
      case (state)
        ST_A1: mem_addr.addr[3:0] <= data_in;
        ST_A2: mem_addr.addr[7:4] <= data_in;
        ST_A3: mem_addr.chip_sel <= data_in;
        ST_M2: begin
          mem_addr.addr <= sel_reg;
          mem_addr.chip_sel <= (!command_line_n && is_pm(decode(op_high, data_in))) ?
                               CS_PROG_MEM : sel_reg[7:4];
        end
        default: ;
      endcase
    end
  end

  // Processor bus drive: fetch nibbles in M1/M2, read results in X2.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      data_out <= NIBBLE_ZERO;
      data_oe_n <= 1'b1;
    end else begin
      data_oe_n <= 1'b1;
      case (state)
        ST_M1: begin
          data_out <= high_nibble_in;
          data_oe_n <= !cmd_a3;
        end
        ST_M2: begin
          data_out <= low_nibble_in;
          data_oe_n <= !cmd_a3;
        end
        ST_X2: begin
          if (kind == INS_READ_PORT) begin
            data_out <= port_data;
            data_oe_n <= 1'b0;
          end else if (kind == INS_READ_PM) begin
            data_out <= half_sel ? high_nibble_in : low_nibble_in;
            data_oe_n <= 1'b0;
          end
        end
        default: ;
      endcase
    end
  end

  // Port data path: read data caught in X1, write data caught at the end of X2.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      port_data <= NIBBLE_ZERO;
      io_out <= NIBBLE_ZERO;
    end else if (state_tick) begin
      if (state == ST_X1 && kind == INS_READ_PORT) begin
        port_data <= io_in;
      end
      if (state == ST_X2 && is_write(kind)) begin
        io_out <= data_in;
      end
    end
  end

  // Port strobes and port buffer enable.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      in_strobe_n <= 1'b1;
      out_strobe_n <= 1'b1;
      io_oe_n <= 1'b1;
    end else begin
      in_strobe_n <= !(is_read(kind) && (state == ST_X1 || state == ST_X2));
      out_strobe_n <= !(is_write(kind) && state == ST_X3);
      io_oe_n <= !(is_write(kind) && state == ST_X3);
    end
  end

  // Program-memory strobe spans X1 through A1 of the following cycle.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pm_active <= 1'b0;
    end else if (state_tick) begin
      if (state == ST_M2 && !command_line_n && is_pm(decode(op_high, data_in))) begin
        pm_active <= 1'b1;
      end else if (state == ST_A1) begin
        pm_active <= 1'b0;
      end
    end
  end

  assign prog_mem_strobe_n = !pm_active;

  // Half-byte flip-flop; an out-of-order mix of reads and writes is not corrected.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      half_sel <= 1'b0;
    end else if (state_tick && state == ST_X3 && is_pm(kind)) begin
      half_sel <= !half_sel;
    end
  end

  assign half_select_n = !half_sel;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  a_fetch_drive_gate: assert property (
    (state == ST_M1 && !cmd_a3) |=> data_oe_n)
    else $error("Bus driven in fetch without command in A3.");

  a_fetch_high_nib: assert property (
    (state == ST_M1 && cmd_a3) |=> (!data_oe_n && data_out == $past(high_nibble_in)))
    else $error("Fetch high nibble not returned in M1.");

  a_addr_low_latch: assert property (
    (state_tick && state == ST_A1) |=> mem_addr.addr[3:0] == $past(data_in))
    else $error("A1 nibble not latched to low address.");

  a_x1_sel_addr: assert property (
    (state_tick && state == ST_M2) |=> mem_addr.addr == $past(sel_reg))
    else $error("Select register not on address outputs in X1.");

  a_pm_cs_force: assert property (
    (state == ST_X1 && is_pm(kind)) |-> mem_addr.chip_sel == CS_PROG_MEM)
    else $error("Chip selects not forced during program-memory access.");

  a_out_strobe_x3: assert property (
    (state == ST_X3 && is_write(kind)) |=> (!out_strobe_n && !io_oe_n))
    else $error("Output strobe missing in X3 of write.");

  a_in_strobe_rd: assert property (
    (state == ST_X1 && is_read(kind)) |=> !in_strobe_n)
    else $error("Input strobe missing for read.");

  a_half_toggle: assert property (
    (state_tick && state == ST_X3 && is_pm(kind)) |=> half_sel != $past(half_sel))
    else $error("Half-byte select did not toggle.");

  a_pm_strobe_end: assert property (
    (state_tick && state == ST_A1) |=> prog_mem_strobe_n)
    else $error("Program-memory strobe not ended after A1.");

  a_rpm_nibble: assert property (
    (state == ST_X2 && kind == INS_READ_PM) |=>
      data_out == ($past(half_sel) ? $past(high_nibble_in) : $past(low_nibble_in)))
    else $error("Wrong nibble returned for program-memory read.");

endmodule : mem_io_bridge

// *** cpu_model.sv ***
// Processor-side model for the memory and I/O bridge: cycle timing, command line, bus nibbles.
// Assumes the bridge samples its inputs on clk edges where state_tick is high.
`timescale 1ns/1ps
module cpu_model (
  // Clock
  input wire logic clk,
  // Timing and bus toward the bridge
  output logic state_tick,
  output logic sync_n,
  output logic command_line_n,
  output logic [3:0] data_in,
  // Bridge outputs watched once per state
  input wire logic [25:0] watch
);
  logic [25:0] obs [8];

  initial begin
    state_tick = 1'b0;
    sync_n = 1'b1;
    command_line_n = 1'b1;
    data_in = 4'h0;
  end

  // One tick per state, three clocks apart, so registered answers settle before capture.
  task automatic run(input logic [11:0] addr, input logic [7:0] op, input logic [7:0] cmd_n,
                     input logic [7:0] xd);
    logic [3:0] nib [8];
    nib = '{addr[3:0], addr[7:4], addr[11:8], op[7:4], op[3:0], 4'h0, xd[7:4], xd[3:0]};
    for (int s = 0; s < 8; s++) begin
      @(posedge clk);
      state_tick <= 1'b1;
      // Nobody drives the bus in X1, so a stale value must not look valid.
      data_in <= (s == 5) ? ~data_in : nib[s];
      command_line_n <= cmd_n[s];
      sync_n <= (s != 7);
      @(posedge clk);
      state_tick <= 1'b0;
      @(posedge clk);
      @(negedge clk);
      obs[(s + 1) % 8] = watch;
    end
  endtask : run
endmodule : cpu_model

// *** cpu_memory_io_interface_bench.sv ***
// Self-checking bench for the memory and I/O bridge.
// Assumes cpu_model drives the processor side; memory and port inputs come from here.
`timescale 1ns/1ps
module cpu_memory_io_interface_bench;
  import mem_io_pkg::*;
  typedef struct packed {
    logic [11:0] addr;
    logic [2:0] kind;
    logic a3;
    logic [7:0] xd;
    logic hs;
    logic [3:0] dx;
  } row_t;
  logic clk, nrst, state_tick, sync_n, command_line_n, data_oe_n, prog_mem_strobe_n;
  logic half_select_n, io_oe_n, in_strobe_n, out_strobe_n;
  logic [3:0] data_in, data_out, high_nibble_in, low_nibble_in, io_in, io_out;
  mem_addr_t mem_addr;
  logic [25:0] o [8];
  logic [7:0] opc [6];
  logic [7:0] cmd, sel;
  logic [2:0] k;
  row_t rw;
  int n_errors, n_checks;
  // Kinds: 0 fetch, 1 select register, 2 write port, 3 read port, 4 write pm, 5 read pm.
  row_t rows [10] = '{'{12'h4A7, 3'd0, 1'b1, 8'h00, 1'b1, 4'h0},
    '{12'hF15, 3'd0, 1'b0, 8'h00, 1'b1, 4'h0}, '{12'h123, 3'd1, 1'b1, 8'h5C, 1'b1, 4'h0},
    '{12'h200, 3'd4, 1'b1, 8'h60, 1'b1, 4'h0}, '{12'h201, 3'd5, 1'b1, 8'h00, 1'b0, 4'hC},
    '{12'h202, 3'd5, 1'b1, 8'h00, 1'b1, 4'h3}, '{12'h203, 3'd2, 1'b1, 8'hB0, 1'b0, 4'h0},
    '{12'h204, 3'd3, 1'b1, 8'h00, 1'b0, 4'h9}, '{12'h205, 3'd1, 1'b1, 8'hE1, 1'b0, 4'h0},
    '{12'hFFF, 3'd0, 1'b1, 8'h00, 1'b0, 4'h0}};

  mem_io_bridge u_mem_io_bridge (.clk(clk), .nrst(nrst), .state_tick(state_tick),
    .sync_n(sync_n), .command_line_n(command_line_n), .data_in(data_in),
    .data_out(data_out), .data_oe_n(data_oe_n), .mem_addr(mem_addr),
    .high_nibble_in(high_nibble_in), .low_nibble_in(low_nibble_in),
    .prog_mem_strobe_n(prog_mem_strobe_n), .half_select_n(half_select_n), .io_in(io_in),
    .io_out(io_out), .io_oe_n(io_oe_n), .in_strobe_n(in_strobe_n),
    .out_strobe_n(out_strobe_n));
  cpu_model u_cpu_model (.clk(clk), .state_tick(state_tick), .sync_n(sync_n),
    .command_line_n(command_line_n), .data_in(data_in),
    .watch({data_oe_n, data_out, io_oe_n, io_out, in_strobe_n, out_strobe_n,
            prog_mem_strobe_n, half_select_n, mem_addr}));

  task automatic chk(input string name, input logic [11:0] seen, input logic [11:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic results();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : results

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Watchdog: a hung run counts as a mismatch.
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    results();
  end

  initial begin
    nrst = 1'b0;
    high_nibble_in = 4'hC;
    low_nibble_in = 4'h3;
    io_in = 4'h9;
    sel = SEL_RESET;
    opc = '{8'h00, 8'h21, {OP_IO_GROUP, OP_WRITE_PORT}, {OP_IO_GROUP, OP_READ_PORT},
            {OP_IO_GROUP, OP_WRITE_PM}, {OP_IO_GROUP, OP_READ_PM}};
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    foreach (rows[r]) begin
      rw = rows[r];
      k = rw.kind;
      cmd = 8'hFF;
      cmd[2] = ~rw.a3;
      cmd[4] = (k < 3'd2);
      if (k == 3'd1) cmd[7:6] = 2'b00;
      u_cpu_model.run(rw.addr, opc[k], cmd, rw.xd);
      o = u_cpu_model.obs;
      chk("addr_m1", o[3][11:0], rw.addr);
      // Logical not keeps the expected enable one bit wide inside the wider argument.
      chk("oe_m1", o[3][25], !rw.a3);
      chk("oe_m2", o[4][25], !rw.a3);
      if (rw.a3) begin
        chk("fetch", {o[3][24:21], o[4][24:21]}, {high_nibble_in, low_nibble_in});
      end
      chk("cs_x1", o[5][11:8], k[2] ? CS_PROG_MEM : sel[7:4]);
      chk("addr_x1", o[5][7:0], sel);
      chk("in_x1", o[5][15], !(k == 3'd3 || k == 3'd5));
      chk("out_x3", o[7][14], !(k == 3'd2 || k == 3'd4));
      chk("io_oe_x3", o[7][20], !(k == 3'd2 || k == 3'd4));
      if (k == 3'd2 || k == 3'd4) chk("io_out", o[7][19:16], rw.xd[7:4]);
      chk("pm_x1", o[5][13], k < 3'd4);
      chk("pm_a1", o[0][13], k < 3'd4);
      chk("half_x2", o[6][12], rw.hs);
      if (k == 3'd3 || k == 3'd5) begin
        chk("rd_x2", {o[6][25], o[6][24:21]}, {1'b0, rw.dx});
      end
      if (k == 3'd1) sel = rw.xd;
    end
    // Mid-run reset while the half-byte flag points at the high nibble.
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    @(negedge clk);
    chk("half_rst", half_select_n, 1'b1);
    results();
  end
endmodule : cpu_memory_io_interface_bench
